/* hdl/psf_server.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: packets open with start byte; hunt for it
// R2: checksum makes routine-through-checksum sum zero
// R3: payload is byte then word, length five
// R4: system info routine 2, port info 8
// R5: word parameter travels most significant first
// R6: totals ignore query fields; reply per slot
// R7: port queries: index in byte parameter
// R8: port settings answer result in byte
// R9: supply index in byte; status/power replies
// R10: soft start, inflation through byte parameter
// R11: system info reply: two strings, length 16
// R12: port info reply echoes routine, length 17
// R13: host ignores port info on nonzero result
// R14: port info multibyte fields most significant first
// R15: full event queue overwrites oldest entry
// R16: event fetch returns all queued events together
// R17: three bytes per event in reply
// R18: no events gives zero length reply
// R19: at most 72 events per reply
// R20: host polls for events periodically
// R21: every host packet uses five byte layout
// R22: fetched events leave the queue
// R23: unused reply slots sent as zeros

module psf_server (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic tx_ready_in,
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  output logic call_valid_out,
  output logic [7:0] call_routine_out,
  output logic [7:0] call_byte_out,
  output logic [31:0] call_word_out,
  input wire logic done_valid_in,
  input wire logic [7:0] done_byte_in,
  input wire logic [31:0] done_word_in,
  input wire logic [psf_pkg::PAY_W-1:0] done_info_in,
  input wire logic evt_valid_in,
  input wire logic [psf_pkg::EVT_W-1:0] evt_data_in
);
  import psf_pkg::*;

  // routine table: codes 1..49 except the gap at 44
  function automatic logic rtn_valid(input logic [7:0] r);
    rtn_valid = (r >= RTN_FIRST) && (r <= RTN_LAST) && (r != RTN_HOLE);
  endfunction : rtn_valid

  // query slots used {byte, word}; the rest are forced to zero
  function automatic logic [1:0] query_slots(input logic [7:0] r);
    case (r)
      8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0E, 8'h0F,
      8'h15, 8'h17, 8'h19, 8'h1B, 8'h2A, 8'h2B, 8'h2E, 8'h2F,
      8'h31: query_slots = 2'b00;
      8'h10, 8'h11, 8'h12, 8'h1C, 8'h1E, 8'h20, 8'h22, 8'h24,
      8'h26: query_slots = 2'b11;
      default: query_slots = 2'b10;
    endcase
  endfunction : query_slots

  // reply slots used {byte, word}; power quantities in the word
  function automatic logic [1:0] reply_slots(input logic [7:0] r);
    case (r)
      8'h03, 8'h04, 8'h05, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h13,
      8'h27, 8'h2F: reply_slots = 2'b01;
      8'h0F, 8'h2B, 8'h2D, 8'h30: reply_slots = 2'b00;
      default: reply_slots = 2'b10;
    endcase
  endfunction : reply_slots

  function automatic logic [7:0] pick_byte(input logic [PAY_W-1:0] v,
                                           input logic [7:0] k);
    logic [PAY_W-1:0] s;
    s = v << (k * 8);
    pick_byte = s[PAY_W-1 -: 8];
  endfunction : pick_byte

  function automatic logic [7:0] evt_byte(input logic [EVT_W-1:0] e,
                                          input logic [1:0] b);
    evt_byte = (b == 2'd0) ? e[23:16] : (b == 2'd1) ? e[15:8] : e[7:0];
  endfunction : evt_byte

  psf_evq_if evq();
  psf_event_queue u_queue (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .q(evq)
  );

  psf_state_t state_r;
  psf_kind_t kind_r;
  logic [7:0] rt_r;
  logic [7:0] rlen_r;
  logic [7:0] cnt_r;
  logic [7:0] rsum_r;
  logic [PARAM_W-1:0] par_r;
  logic [PAY_W-1:0] pay_r;
  logic [7:0] tlen_r;
  logic [7:0] idx_r;
  logic [7:0] tsum_r;
  logic [1:0] evb_r;
  logic tx_valid_r;
  logic [7:0] tx_byte_r;
  logic call_valid_r;
  logic [7:0] call_rt_r;
  logic [7:0] call_b_r;
  logic [31:0] call_w_r;

  // receive side decode
  wire rx_take = rx_valid_in;
  wire [7:0] rsum_nxt = rsum_r + rx_byte_in;
  // bad sum, wrong length or unknown routine: dropped silently
  wire pkt_ok = (rsum_nxt == 8'h00) && (rlen_r == LEN_PARAM) // R2 R21
                && rtn_valid(rt_r);
  wire [1:0] qs = query_slots(rt_r);
  wire [1:0] rs = reply_slots(rt_r);
  wire [7:0] evt_len = {1'b0, evq.count} * EVT_BYTES; // R17 R19

  // transmit side selection
  wire tx_fire = tx_valid_r & tx_ready_in;
  wire [7:0] idx_n = idx_r + 1'b1;
  wire [7:0] sum_pos = tlen_r + HDR_BYTES;
  wire tx_last = (idx_r == sum_pos);
  wire cur_is_data = (idx_r >= HDR_BYTES) && !tx_last;
  wire [7:0] tsum_nxt = tsum_r + ((idx_r == 8'h00) ? 8'h00 : tx_byte_r);
  wire [7:0] csum_byte = 8'h00 - tsum_nxt; // R2
  wire [7:0] d_off = idx_n - HDR_BYTES;
  wire [1:0] evb_n = (idx_r < HDR_BYTES || evb_r == 2'd2) ? 2'd0
                     : evb_r + 1'b1;
  // crossing into the next event reads the entry behind the head
  wire pop_now = tx_fire && (kind_r == K_EVT) && cur_is_data
                 && (evb_r == 2'd2); // R22
  wire [7:0] evt_next = (cur_is_data && evb_r == 2'd2)
                        ? evt_byte(evq.next_data, 2'd0)
                        : evt_byte(evq.head_data, evb_n); // R16
  wire [7:0] data_next = (kind_r == K_EVT) ? evt_next
                         : pick_byte(pay_r, d_off); // R5 R14
  wire [7:0] tx_next = (idx_n == 8'h01) ? rt_r
                       : (idx_n == 8'h02) ? tlen_r
                       : (idx_n == sum_pos) ? csum_byte : data_next;

  // event queue hookup; power manager events go straight in
  assign evq.push = evt_valid_in; // R15
  assign evq.push_data = evt_data_in;
  assign evq.pop = pop_now;

  // parser, dispatcher and sender; bytes outside receive states are lost
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_r <= S_HUNT;
      kind_r <= K_PARAM;
      rt_r <= 8'h00;
      rlen_r <= 8'h00;
      cnt_r <= 8'h00;
      rsum_r <= 8'h00;
      par_r <= '0;
      pay_r <= '0;
      tlen_r <= 8'h00;
      idx_r <= 8'h00;
      tsum_r <= 8'h00;
      evb_r <= 2'd0;
      tx_valid_r <= 1'b0;
      tx_byte_r <= 8'h00;
      call_valid_r <= 1'b0;
      call_rt_r <= 8'h00;
      call_b_r <= 8'h00;
      call_w_r <= 32'h00000000;
    end
    else
    begin
      case (state_r)
        S_HUNT:
        begin
          if (rx_take && rx_byte_in == PSF_SOP) // R1
          begin
            state_r <= S_ROUT;
          end
        end
        S_ROUT:
        begin
          if (rx_take)
          begin
            rt_r <= rx_byte_in;
            rsum_r <= rx_byte_in;
            state_r <= S_LEN;
          end
        end
        S_LEN:
        begin
          if (rx_take)
          begin
            rlen_r <= rx_byte_in;
            rsum_r <= rsum_nxt;
            cnt_r <= 8'h00;
            state_r <= (rx_byte_in == 8'h00) ? S_SUM : S_DATA;
          end
        end
        S_DATA:
        begin
          if (rx_take)
          begin
            // byte parameter first, then the word, top byte first
            par_r <= {par_r[PARAM_W-9:0], rx_byte_in}; // R3 R5
            rsum_r <= rsum_nxt;
            cnt_r <= cnt_r + 1'b1;
            state_r <= (cnt_r == rlen_r - 1'b1) ? S_SUM : S_DATA;
          end
        end
        S_SUM:
        begin
          if (rx_take)
          begin
            if (!pkt_ok)
            begin
              state_r <= S_HUNT;
            end
            else if (rt_r == RTN_SYS_INFO) // R4
            begin
              kind_r <= K_SYS;
              tlen_r <= LEN_SYS_INFO; // R11
              pay_r <= {MGR_VERSION, PLAT_VERSION, 8'h00};
              state_r <= S_LOAD;
            end
            else if (rt_r == RTN_EVENTS)
            begin
              kind_r <= K_EVT;
              tlen_r <= evt_len; // R16 R18
              state_r <= S_LOAD;
            end
            else
            begin
              // unused query fields never reach the manager
              call_valid_r <= 1'b1;
              call_rt_r <= rt_r;
              call_b_r <= qs[1] ? par_r[39:32] : 8'h00; // R6 R7 R9 R10
              call_w_r <= qs[0] ? par_r[31:0] : 32'h00000000; // R8
              state_r <= S_CALL;
            end
          end
        end
        S_CALL:
        begin
          if (done_valid_in)
          begin
            call_valid_r <= 1'b0;
            if (rt_r == RTN_PORT_INFO) // R4
            begin
              kind_r <= K_PORT;
              tlen_r <= LEN_PORT_INFO; // R12
              pay_r <= done_info_in; // R14
            end
            else
            begin
              kind_r <= K_PARAM;
              tlen_r <= LEN_PARAM; // R3
              pay_r <= {rs[1] ? done_byte_in : 8'h00, // R23
                        rs[0] ? done_word_in : 32'h00000000,
                        {(PAY_W - PARAM_W){1'b0}}};
            end
            state_r <= S_LOAD;
          end
        end
        S_LOAD:
        begin
          tx_valid_r <= 1'b1;
          tx_byte_r <= PSF_SOP; // R1
          idx_r <= 8'h00;
          tsum_r <= 8'h00;
          evb_r <= 2'd0;
          state_r <= S_SEND;
        end
        S_SEND:
        begin
          if (tx_fire)
          begin
            if (tx_last)
            begin
              tx_valid_r <= 1'b0;
              state_r <= S_HUNT;
            end
            else
            begin
              idx_r <= idx_n;
              tsum_r <= tsum_nxt;
              tx_byte_r <= tx_next;
              evb_r <= evb_n;
            end
          end
        end
        default:
        begin
          state_r <= S_HUNT;
        end
      endcase
    end
  end

  assign tx_valid_out = tx_valid_r;
  assign tx_byte_out = tx_byte_r;
  assign call_valid_out = call_valid_r;
  assign call_routine_out = call_rt_r;
  assign call_byte_out = call_b_r;
  assign call_word_out = call_w_r;

  a_sop_first: assert property ( // R1
    @(posedge ref_clk_in) disable iff (rst_in)
    $rose(tx_valid_r) |-> tx_byte_r == PSF_SOP)
    else $error("reply did not open with start byte");

  a_sum_zero: assert property ( // R2
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_r && tx_last) |-> (8'(tsum_r + tx_byte_r) == 8'h00))
    else $error("reply checksum wrong");

  a_param_len: assert property ( // R3
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_r && idx_r == 8'h02 && kind_r == K_PARAM)
    |-> tx_byte_r == LEN_PARAM)
    else $error("parameter reply length not five");

  a_echo_routine: assert property ( // R4
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_r && idx_r == 8'h01) |-> tx_byte_r == rt_r)
    else $error("routine not echoed");

  a_sys_len: assert property ( // R11
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_r && idx_r == 8'h02 && kind_r == K_SYS)
    |-> tx_byte_r == LEN_SYS_INFO)
    else $error("system info length wrong");

  a_port_len: assert property ( // R12
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_r && idx_r == 8'h02 && kind_r == K_PORT)
    |-> tx_byte_r == LEN_PORT_INFO)
    else $error("port info length wrong");

  a_evt_len: assert property ( // R17
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_r && idx_r == 8'h02 && kind_r == K_EVT)
    |-> (tx_byte_r % EVT_BYTES == 8'h00) && (tx_byte_r <= 8'hD8))
    else $error("event reply length not whole events");

  a_unused_zero: assert property ( // R23
    @(posedge ref_clk_in) disable iff (rst_in)
    (tx_valid_r && idx_r == 8'h03 && kind_r == K_PARAM && !rs[1])
    |-> tx_byte_r == 8'h00)
    else $error("unused byte slot not zero");

  a_call_hold: assert property ( // R7
    @(posedge ref_clk_in) disable iff (rst_in)
    (call_valid_r && !done_valid_in)
    |=> call_valid_r && $stable(call_b_r) && $stable(call_w_r))
    else $error("manager call dropped before answer");

endmodule : psf_server

`default_nettype wire

/* hdl/psf_pkg.sv */
package psf_pkg;

  // framing
  localparam logic [7:0] PSF_SOP = 8'hAC;
  localparam logic [7:0] PSF_ZERO_BYTE = 8'h00;
  localparam logic [7:0] LEN_PARAM = 8'h05;
  localparam logic [7:0] LEN_SYS_INFO = 8'h10;
  localparam logic [7:0] LEN_PORT_INFO = 8'h11;
  localparam logic [7:0] EVT_BYTES = 8'h03;
  localparam logic [7:0] HDR_BYTES = 8'h03;

  // routine code range, gap and codes with special handling
  localparam logic [7:0] RTN_FIRST = 8'h01;
  localparam logic [7:0] RTN_SYS_INFO = 8'h02;
  localparam logic [7:0] RTN_PORT_INFO = 8'h08;
  localparam logic [7:0] RTN_EVENTS = 8'h2A;
  localparam logic [7:0] RTN_HOLE = 8'h2C;
  localparam logic [7:0] RTN_LAST = 8'h31;

  // widths and depths
  localparam int EVT_W = 24;
  localparam int EVQ_DEPTH = 72;
  localparam int EVQ_AW = 7;
  localparam int PAY_W = 136;
  localparam int PARAM_W = 40;

  // version strings, ascii, zero terminated, eight bytes each
  localparam logic [63:0] MGR_VERSION = 64'h312E300000000000;
  localparam logic [63:0] PLAT_VERSION = 64'h312E300000000000;

  typedef enum logic [2:0] {
    S_HUNT, S_ROUT, S_LEN, S_DATA, S_SUM, S_CALL, S_LOAD, S_SEND
  } psf_state_t;

  typedef enum logic [1:0] {
    K_PARAM, K_SYS, K_PORT, K_EVT
  } psf_kind_t;

endpackage : psf_pkg

/* hdl/psf_evq_if.sv */
`timescale 1ns/1ps
`default_nettype none

// event queue handshake between the server and its queue
interface psf_evq_if;
  import psf_pkg::*;
  logic push;
  logic [EVT_W-1:0] push_data;
  logic pop;
  logic [EVT_W-1:0] head_data;
  logic [EVT_W-1:0] next_data;
  logic [EVQ_AW-1:0] count;

  modport queue (
    input push, push_data, pop,
    output head_data, next_data, count
  );
  modport user (
    output push, push_data, pop,
    input head_data, next_data, count
  );
endinterface : psf_evq_if

`default_nettype wire

/* hdl/psf_event_queue.sv */
`timescale 1ns/1ps
`default_nettype none

module psf_event_queue (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  psf_evq_if.queue q
);
  import psf_pkg::*;

  localparam logic [EVQ_AW-1:0] LAST_SLOT = EVQ_AW'(EVQ_DEPTH - 1);
  localparam logic [EVQ_AW-1:0] FULL_CNT = EVQ_AW'(EVQ_DEPTH);

  function automatic logic [EVQ_AW-1:0] wrap(input logic [EVQ_AW-1:0] p);
    wrap = (p == LAST_SLOT) ? '0 : p + 1'b1;
  endfunction : wrap

  logic [EVT_W-1:0] mem_r [EVQ_DEPTH];
  logic [EVQ_AW-1:0] wr_r;
  logic [EVQ_AW-1:0] rd_r;
  logic [EVQ_AW-1:0] cnt_r;
  logic [EVQ_AW-1:0] rd_nxt;
  logic [EVQ_AW-1:0] cnt_nxt;
  wire full = (cnt_r == FULL_CNT);
  wire do_pop = q.pop & (cnt_r != '0);
  // full queue: newest event pushes the oldest out
  wire drop = q.push & full & ~do_pop; // R15

  // pointer and count steering
  assign rd_nxt = (do_pop | drop) ? wrap(rd_r) : rd_r;
  assign cnt_nxt = (q.push & ~do_pop & ~full) ? cnt_r + 1'b1 :
                   (~q.push & do_pop) ? cnt_r - 1'b1 : cnt_r;
  assign q.head_data = mem_r[rd_r];
  assign q.next_data = mem_r[wrap(rd_r)];
  assign q.count = cnt_r;

  // storage is not reset; count guards every read
  always_ff @(posedge ref_clk_in)
  begin
    if (q.push)
    begin
      mem_r[wr_r] <= q.push_data;
    end
  end

  // pointers
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wr_r <= q.push ? wrap(wr_r) : wr_r;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  a_depth_bound: assert property ( // R19
    @(posedge ref_clk_in) disable iff (rst_in) cnt_r <= FULL_CNT)
    else $error("event queue count above depth");

  a_overwrite_old: assert property ( // R15
    @(posedge ref_clk_in) disable iff (rst_in)
    drop |=> (cnt_r == FULL_CNT) && (rd_r == wrap($past(rd_r))))
    else $error("full push did not drop oldest event");

  a_pop_removes: assert property ( // R22
    @(posedge ref_clk_in) disable iff (rst_in)
    (do_pop && !q.push) |=> cnt_r == $past(cnt_r) - 1'b1)
    else $error("fetched event not removed");

endmodule : psf_event_queue

`default_nettype wire

/* verification/psf_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// host side packet client: sends queries, collects reply bytes
module psf_host_model (
  input wire logic ref_clk_in,
  input wire logic slow_in,
  input wire logic rnd_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  output logic tx_ready_out,
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out
);
  logic [7:0] got_q[$];

  initial
  begin
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h00;
    tx_ready_out = 1'b0;
  end

  // take reply bytes; a slow host stalls at random
  always @(posedge ref_clk_in)
  begin
    if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1)
      got_q.push_back(tx_byte_in);
    tx_ready_out <= slow_in ? rnd_in : 1'b1;
  end

  // one byte a cycle; idle line shows the inverse, never stale data
  task automatic put(input logic [7:0] b, input logic v);
    @(posedge ref_clk_in);
    rx_valid_out <= v;
    rx_byte_out <= v ? b : ~rx_byte_out;
  endtask : put

  // err is added to the checksum to corrupt it on purpose
  task automatic send(input logic [7:0] rt, input logic [7:0] len,
                      input logic [7:0] b8, input logic [31:0] w,
                      input logic [7:0] err);
    logic [7:0] s;
    s = rt + len + b8 + w[31:24] + w[23:16] + w[15:8] + w[7:0];
    put(8'hAC, 1'b1);
    put(rt, 1'b1);
    put(len, 1'b1);
    put(b8, 1'b1);
    put(w[31:24], 1'b1);
    put(w[23:16], 1'b1);
    put(w[15:8], 1'b1);
    put(w[7:0], 1'b1);
    put(~s + 8'h01 + err, 1'b1);
    put(8'h00, 1'b0);
  endtask : send
endmodule : psf_host_model

`default_nettype wire

/* verification/psf_server_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module psf_server_tb_top;
  import psf_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  wire logic rx_valid_in;
  wire logic [7:0] rx_byte_in;
  wire logic tx_ready_in;
  logic tx_valid_out, call_valid_out;
  logic [7:0] tx_byte_out, call_routine_out, call_byte_out;
  logic [31:0] call_word_out;
  logic done_valid_in = 1'b0;
  logic [7:0] done_byte_in = 8'h00;
  logic [31:0] done_word_in = 32'h0;
  logic [PAY_W-1:0] done_info_in = '0;
  logic evt_valid_in = 1'b0;
  logic [EVT_W-1:0] evt_data_in = '0;
  integer seed = 32'hd839;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int lat = 0;
  int wait_n = 0;
  int ncalls = 0;
  logic slow = 1'b0;
  logic rnd = 1'b1;
  logic [31:0] r32;
  logic [7:0] c_rt, c_b, md_b;
  logic [31:0] c_w, md_w;
  logic [PAY_W-1:0] md_i;
  logic [7:0] exp_q[$];
  logic [23:0] evq[$];

  psf_server uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in),
    .tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
    .tx_byte_out(tx_byte_out), .call_valid_out(call_valid_out),
    .call_routine_out(call_routine_out), .call_byte_out(call_byte_out),
    .call_word_out(call_word_out), .done_valid_in(done_valid_in),
    .done_byte_in(done_byte_in), .done_word_in(done_word_in),
    .done_info_in(done_info_in), .evt_valid_in(evt_valid_in),
    .evt_data_in(evt_data_in));

  psf_host_model host (.ref_clk_in(ref_clk_in), .slow_in(slow),
    .rnd_in(rnd), .tx_valid_in(tx_valid_out), .tx_byte_in(tx_byte_out),
    .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in),
    .rx_byte_out(rx_byte_in));

  always #20 ref_clk_in = ~ref_clk_in;

  // manager stand-in: answers each call after lat waiting cycles, set per routine by the test
  always @(posedge ref_clk_in)
  begin
    r32 = $random(seed);
    rnd <= r32[0];
    done_valid_in <= 1'b0;
    if (call_valid_out === 1'b1 && done_valid_in === 1'b0)
    begin
      if (wait_n >= lat)
      begin
        c_rt = call_routine_out;
        c_b = call_byte_out;
        c_w = call_word_out;
        md_b = r32[15:8];
        md_w = $random(seed);
        md_i = {$random(seed), $random(seed), $random(seed), md_w, md_b};
        done_valid_in <= 1'b1;
        done_byte_in <= md_b;
        done_word_in <= md_w;
        done_info_in <= md_i;
        ncalls++;
        wait_n = 0;
      end
      else
        wait_n++;
    end
  end

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge ref_clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // the answer values are only known once the manager has replied
  task automatic wait_call(input int n);
    int k;
    k = 0;
    while (ncalls == n && k < 50)
    begin
      @(posedge ref_clk_in);
      k++;
    end
  endtask : wait_call

  // expected reply: header now, checksum appended by check_reply
  task automatic start_exp(input logic [7:0] rt, input int len);
    exp_q = {8'hAC, rt, 8'(len)};
  endtask : start_exp

  task automatic push_w(input logic [31:0] w);
    for (int i = 3; i >= 0; i--)
      exp_q.push_back(w[8*i +: 8]);
  endtask : push_w

  task automatic check_reply();
    logic [7:0] s;
    int k;
    s = 8'h00;
    k = 0;
    for (int i = 1; i < exp_q.size(); i++)
      s = s + exp_q[i];
    exp_q.push_back(~s + 8'h01);
    while ((host.got_q.size() < exp_q.size() || tx_valid_out !== 1'b0)
           && k < 3000)
    begin
      @(posedge ref_clk_in);
      k++;
    end
    repeat (3) @(posedge ref_clk_in);
    chk("reply length", exp_q.size(), host.got_q.size());
    for (int i = 0; i < exp_q.size() && i < host.got_q.size(); i++)
      chk("reply byte", exp_q[i], host.got_q[i]);
    host.got_q.delete();
  endtask : check_reply

  // events go into the model queue too; oldest dropped past 72
  task automatic push_evt(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in);
      r32 = $random(seed);
      evt_valid_in <= 1'b1;
      evt_data_in <= r32[23:0];
      evq.push_back(r32[23:0]);
      if (evq.size() > 72)
        evq.pop_front();
    end
    @(posedge ref_clk_in);
    evt_valid_in <= 1'b0;
  endtask : push_evt

  task automatic fetch_evt();
    host.send(RTN_EVENTS, 8'h05, 8'h00, 32'h0, 8'h00);
    start_exp(RTN_EVENTS, 3 * evq.size());
    foreach (evq[i])
      for (int j = 2; j >= 0; j--)
        exp_q.push_back(evq[i][8*j +: 8]);
    check_reply();
    evq.delete();
  endtask : fetch_evt

  initial
  begin
    logic [7:0] b8;
    logic [31:0] w;
    int n0;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    chk("idle tx valid", 1'b0, tx_valid_out);
    chk("idle call valid", 1'b0, call_valid_out);
    // parameter routines: query fields, reply slots, word byte order
    for (int r = 1; r <= 49; r++)
    begin
      if (r inside {2, 8, 42, 44})
        continue;
      b8 = $random(seed);
      w = $random(seed);
      lat = r % 4;
      slow = r[0];
      n0 = ncalls;
      host.send(8'(r), 8'h05, b8, w, 8'h00);
      wait_call(n0);
      start_exp(8'(r), 5);
      exp_q.push_back(r inside {3, 4, 5, 10, 11, 12, 13, 19, 39, 47,
                                15, 43, 45, 48} ? 8'h00 : md_b);
      push_w(r inside {3, 4, 5, 10, 11, 12, 13, 19, 39, 47} ?
             md_w : 32'h0);
      check_reply();
      chk("call routine", r, c_rt);
      chk("call byte", r inside {[1:6], 14, 15, 21, 23, 25, 27, 43, 46, 47,
                                 49} ? 8'h00 : b8, c_b);
      chk("call word", r inside {16, 17, 18, 28, 30, 32, 34, 36, 38} ?
          w : 32'h0, c_w);
    end
    $display("test parameter routines done");
    // system info needs no manager call
    n0 = ncalls;
    host.send(RTN_SYS_INFO, 8'h05, 8'h00, 32'h0, 8'h00);
    start_exp(RTN_SYS_INFO, 16);
    push_w(MGR_VERSION[63:32]);
    push_w(MGR_VERSION[31:0]);
    push_w(PLAT_VERSION[63:32]);
    push_w(PLAT_VERSION[31:0]);
    check_reply();
    chk("sys info calls", n0, ncalls);
    host.send(RTN_PORT_INFO, 8'h05, 8'h17, 32'h0, 8'h00);
    wait_call(n0);
    start_exp(RTN_PORT_INFO, 17);
    // fields past a nonzero result are opaque to the host; all sent as given
    for (int i = 16; i >= 0; i--)
      exp_q.push_back(md_i[8*i +: 8]);
    check_reply();
    chk("port info byte", 8'h17, c_b);
    $display("test info replies done");
    // events: empty, a few, drained, then overflow
    fetch_evt();
    push_evt(5);
    fetch_evt();
    fetch_evt();
    slow = 1'b1;
    push_evt(75);
    fetch_evt();
    slow = 1'b0;
    $display("test event queue done");
    // broken packets draw no call and no reply
    n0 = ncalls;
    host.put(8'h13, 1'b1);
    host.send(8'h01, 8'h05, 8'h00, 32'h0, 8'h01);
    host.send(8'h2C, 8'h05, 8'h00, 32'h0, 8'h00);
    host.send(8'h01, 8'h04, 8'h00, 32'h0, 8'h00);
    repeat (30) @(posedge ref_clk_in);
    chk("dropped replies", 0, host.got_q.size());
    chk("dropped calls", n0, ncalls);
    host.put(8'h55, 1'b1);
    host.send(8'h01, 8'h05, 8'h00, 32'h0, 8'h00);
    wait_call(n0);
    start_exp(8'h01, 5);
    exp_q.push_back(md_b);
    push_w(32'h0);
    check_reply();
    $display("test broken packets done");
    give_verdict();
  end
endmodule : psf_server_tb_top

`default_nettype wire
